// ===== common/rag_consts.svh
`ifndef RAG_CONSTS_SVH
`define RAG_CONSTS_SVH

// register byte offsets
`define RAG_PROG_PERM_BASE 12'h000
`define RAG_RAM_PERM_BASE 12'h100
`define RAG_PROG_ENTRY_BASE 12'h200
`define RAG_RAM_ENTRY_BASE 12'h208
`define RAG_EVT_PROG 12'h300
`define RAG_EVT_RAM 12'h304
`define RAG_INTEN 12'h308
`define RAG_ARRAY_MASK 12'hf80
`define RAG_ENTRY_MASK 12'hff8

// field positions
`define RAG_PERM_LOCK 8
`define RAG_ENTRY_SIZE_LSB 8

// reset values
`define RAG_PERM_RESET 4'hf
`define RAG_ENTRY_RESET 8'h00

// space geometry
`define RAG_NUM_REGIONS 32
`define RAG_NUM_ENTRY 2
`define RAG_PROG_ADDR_W 20
`define RAG_PROG_RGN_SHIFT 15
`define RAG_RAM_ADDR_W 18
`define RAG_RAM_RGN_SHIFT 13
`define RAG_ENTRY_BASE_SHIFT 4

`endif

// ===== common/rag_pkg.sv
`default_nettype none
package rag_pkg;
  typedef enum logic [1:0] {rag_read, rag_write, rag_erase, rag_fetch} rag_kind_t;
  typedef enum logic [1:0] {rag_main, rag_user_cfg, rag_factory_cfg} rag_area_t;
  typedef enum logic [1:0] {rag_core, rag_dma, rag_other} rag_master_t;
  typedef struct packed {
    logic secure;
    logic exec;
    logic write;
    logic read;
  } rag_perm_t;
  typedef struct packed {
    logic [2:0] size;
    logic [4:0] region;
  } rag_entry_t;
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
    rag_kind_t kind;
    rag_area_t area;
    logic secure;
    rag_master_t master;
    logic err_capable;
    logic debug;
  } rag_req_t;
  typedef struct packed {
    logic grant;
    logic bus_error;
    logic entry;
    logic [31:0] rdata;
  } rag_resp_t;
endpackage
`default_nettype wire

// ===== logic/rag_region_check.sv
`include "rag_consts.svh"
`default_nettype none
module rag_region_check #(
  parameter int ADDR_W = 20,
  parameter int RGN_SHIFT = 15
) (
  input wire rag_pkg::rag_req_t req,
  input wire rag_pkg::rag_perm_t [31:0] perms,
  input wire rag_pkg::rag_entry_t [1:0] entries,
  output logic sec_viol,
  output logic rwx_viol,
  output logic entry_hit
);
  wire logic [4:0] idx = req.addr[ADDR_W-1:RGN_SHIFT];
  wire logic [RGN_SHIFT-1:0] off = req.addr[RGN_SHIFT-1:0];
  wire logic in_main = req.area == rag_pkg::rag_main;
  wire logic factory = req.area == rag_pkg::rag_factory_cfg;
  // config areas: always secure, never executable, factory read only
  wire rag_pkg::rag_perm_t cfg_perm = '{secure: 1'b1, exec: 1'b0, write: ~factory, read: 1'b1};
  wire rag_pkg::rag_perm_t perm = in_main ? perms[idx] : cfg_perm;
  wire logic is_wr = req.kind == rag_pkg::rag_write || req.kind == rag_pkg::rag_erase;
  wire logic rd_bad = req.kind == rag_pkg::rag_read && !perm.read;
  wire logic wr_bad = is_wr && !perm.write;
  // debug may step through non-executable code and config areas
  wire logic fx_bad = req.kind == rag_pkg::rag_fetch && !perm.exec && !req.debug;
  logic [2:0] max_size [0:`RAG_NUM_ENTRY];
  assign max_size[0] = 3'h0;
  for (genvar g = 0; g < `RAG_NUM_ENTRY; g++) begin : g_entry
    // selecting a non-secure region yields no sub-region
    wire logic live = entries[g].size != 3'h0 && perms[entries[g].region].secure;
    wire logic match = live && entries[g].region == idx;
    wire logic bigger = entries[g].size > max_size[g];
    assign max_size[g+1] = (match && bigger) ? entries[g].size : max_size[g];
  end
  wire logic [3:0] shamt = 4'(max_size[`RAG_NUM_ENTRY]) + 4'(`RAG_ENTRY_BASE_SHIFT);
  wire logic [RGN_SHIFT:0] span = (max_size[`RAG_NUM_ENTRY] == 3'h0) ? '0 : (RGN_SHIFT+1)'(1) << shamt;
  // carry out means offset lies within span of the region top
  wire logic [RGN_SHIFT:0] top_sum = {1'b0, off} + span;
  assign sec_viol = req.valid && perm.secure && !req.secure;
  assign rwx_viol = req.valid && (rd_bad || wr_bad || fx_bad);
  assign entry_hit = req.valid && in_main && top_sum[RGN_SHIFT];
endmodule
`default_nettype wire

// ===== logic/rag_fault_route.sv
`default_nettype none
module rag_fault_route (
  input wire logic valid,
  input wire rag_pkg::rag_master_t master,
  input wire logic sec_viol,
  input wire logic rwx_viol,
  output logic secure_fault,
  output logic bus_fault,
  output logic access_event
);
  wire logic core = master == rag_pkg::rag_core;
  wire logic any_viol = sec_viol || rwx_viol;
  assign secure_fault = valid && core && sec_viol;
  assign bus_fault = valid && core && !sec_viol && rwx_viol;
  // core security faults stay off the event line
  assign access_event = valid && (core ? (!sec_viol && rwx_viol) : any_viol);
endmodule
`default_nettype wire

// ===== logic/rag_guard.sv
// Contract
// - program space 32 regions of 32 KiB, RAM 32 regions of 8 KiB
// - read permission covers data reads; fetches check execute only
// - program write permission covers writes and erases
// - fetch succeeds with execute granted even without read
// - secure region admits only secure transfers
// - permissions set independently; lock refuses further changes
// - debugger fetches ignore missing execute permission
// - entry sub-regions described by region select and size
// - entry sub-region sits at region top, growing downward
// - entry sub-region live only with non-zero size and secure region
// - two descriptors on one region give the larger size
// - descriptor on non-secure region makes no sub-region
// - violating transfer blocked, blocked read returns zero
// - bus error to masters that support it, none otherwise
// - core security violation raises secure fault, no access event
// - core read/write/execute violation raises bus fault and event
// - non-core violations read zero, ignore writes, raise event
// - RAM violations raise RAM event except core security ones
// - security beats permission violation for core faults
// - each access event can raise an interrupt when enabled
// - config areas always secure; factory read only
// - fetch from config areas violates except under debug
// - blocked write leaves target unchanged, blocked read gives zero
`include "rag_consts.svh"
`default_nettype none
module rag_guard (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rag_pkg::rag_req_t prog_req,
  input wire logic [31:0] prog_mem_rdata,
  output rag_pkg::rag_resp_t prog_resp,
  input wire rag_pkg::rag_req_t ram_req,
  input wire logic [31:0] ram_mem_rdata,
  output rag_pkg::rag_resp_t ram_resp,
  output logic secure_fault_a,
  output logic bus_fault_b,
  output logic prog_access_error_event,
  output logic ram_access_error_event,
  output logic irq
);
  rag_pkg::rag_perm_t [31:0] prog_perm;
  rag_pkg::rag_perm_t [31:0] ram_perm;
  logic [31:0] prog_region_lock;
  logic [31:0] ram_region_lock;
  rag_pkg::rag_entry_t [1:0] prog_entry;
  rag_pkg::rag_entry_t [1:0] ram_entry;
  logic evt_prog;
  logic evt_ram;
  logic [1:0] inten;

  // apb decode
  wire logic access = psel && penable;
  wire logic first_access = access && !pready;
  wire logic commit = access && pready;
  wire logic wr_en = commit && pwrite;
  wire logic aligned = paddr[1:0] == 2'h0;
  wire logic [4:0] ridx = paddr[6:2];
  wire logic eidx = paddr[2];
  wire logic sel_pp = aligned && (paddr & `RAG_ARRAY_MASK) == `RAG_PROG_PERM_BASE;
  wire logic sel_rp = aligned && (paddr & `RAG_ARRAY_MASK) == `RAG_RAM_PERM_BASE;
  wire logic sel_pe = aligned && (paddr & `RAG_ENTRY_MASK) == `RAG_PROG_ENTRY_BASE;
  wire logic sel_re = aligned && (paddr & `RAG_ENTRY_MASK) == `RAG_RAM_ENTRY_BASE;
  wire logic sel_ep = paddr == `RAG_EVT_PROG;
  wire logic sel_er = paddr == `RAG_EVT_RAM;
  wire logic sel_ie = paddr == `RAG_INTEN;
  wire logic mapped = sel_pp || sel_rp || sel_pe || sel_re || sel_ep || sel_er || sel_ie;
  wire rag_pkg::rag_perm_t wr_perm = rag_pkg::rag_perm_t'(pwdata[3:0]);
  wire logic wr_lock = pwdata[`RAG_PERM_LOCK];
  wire rag_pkg::rag_entry_t wr_entry = rag_pkg::rag_entry_t'({pwdata[`RAG_ENTRY_SIZE_LSB +: 3], pwdata[4:0]});

  wire logic [31:0] rd_pp = {23'h0, prog_region_lock[ridx], 4'h0, prog_perm[ridx]};
  wire logic [31:0] rd_rp = {23'h0, ram_region_lock[ridx], 4'h0, ram_perm[ridx]};
  wire logic [31:0] rd_pe = {21'h0, prog_entry[eidx].size, 3'h0, prog_entry[eidx].region};
  wire logic [31:0] rd_re = {21'h0, ram_entry[eidx].size, 3'h0, ram_entry[eidx].region};
  wire logic [31:0] rd_word = sel_pp ? rd_pp :
                              sel_rp ? rd_rp :
                              sel_pe ? rd_pe :
                              sel_re ? rd_re :
                              sel_ep ? {31'h0, evt_prog} :
                              sel_er ? {31'h0, evt_ram} :
                              sel_ie ? {30'h0, inten} : 32'h0;

  // one wait state gives time to register read data
  wire logic next_pready = first_access;
  wire logic next_pslverr = first_access && !mapped;
  wire logic [31:0] next_prdata = (first_access && !pwrite) ? rd_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // zero outside the answer cycle, so a stale word never lingers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // permission registers; a set lock freezes its region
  // reset leaves every region fully open but secure
  for (genvar g = 0; g < `RAG_NUM_REGIONS; g++) begin : g_region
    wire logic hit = wr_en && ridx == 5'(g);
    wire logic prog_wr = hit && sel_pp && !prog_region_lock[g];
    wire logic ram_wr = hit && sel_rp && !ram_region_lock[g];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prog_perm[g] <= rag_pkg::rag_perm_t'(`RAG_PERM_RESET);
        prog_region_lock[g] <= 1'b0;
      end else if (prog_wr) begin
        prog_perm[g] <= wr_perm;
        prog_region_lock[g] <= wr_lock;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ram_perm[g] <= rag_pkg::rag_perm_t'(`RAG_PERM_RESET);
        ram_region_lock[g] <= 1'b0;
      end else if (ram_wr) begin
        ram_perm[g] <= wr_perm;
        ram_region_lock[g] <= wr_lock;
      end
    end
  end

  // entry descriptors
  // descriptors stay writable; only permission words lock
  for (genvar g = 0; g < `RAG_NUM_ENTRY; g++) begin : g_desc
    wire logic hit = wr_en && eidx == 1'(g);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prog_entry[g] <= rag_pkg::rag_entry_t'(`RAG_ENTRY_RESET);
        ram_entry[g] <= rag_pkg::rag_entry_t'(`RAG_ENTRY_RESET);
      end else begin
        if (hit && sel_pe) begin
          prog_entry[g] <= wr_entry;
        end
        if (hit && sel_re) begin
          ram_entry[g] <= wr_entry;
        end
      end
    end
  end

  // region checks, one per space
  logic prog_sec;
  logic prog_rwx;
  logic prog_hit;
  logic ram_sec;
  logic ram_rwx;
  logic ram_hit;

  rag_region_check #(
    .ADDR_W(`RAG_PROG_ADDR_W),
    .RGN_SHIFT(`RAG_PROG_RGN_SHIFT)
  ) u_prog_check (
    .req(prog_req),
    .perms(prog_perm),
    .entries(prog_entry),
    .sec_viol(prog_sec),
    .rwx_viol(prog_rwx),
    .entry_hit(prog_hit)
  );

  // ram space has no config areas
  rag_pkg::rag_req_t ram_req_main;
  always_comb begin
    ram_req_main = ram_req;
    ram_req_main.area = rag_pkg::rag_main;
  end

  rag_region_check #(
    .ADDR_W(`RAG_RAM_ADDR_W),
    .RGN_SHIFT(`RAG_RAM_RGN_SHIFT)
  ) u_ram_check (
    .req(ram_req_main),
    .perms(ram_perm),
    .entries(ram_entry),
    .sec_viol(ram_sec),
    .rwx_viol(ram_rwx),
    .entry_hit(ram_hit)
  );

  logic prog_sf;
  logic prog_bf;
  logic prog_ev;
  logic ram_sf;
  logic ram_bf;
  logic ram_ev;

  rag_fault_route u_prog_route (
    .valid(prog_req.valid),
    .master(prog_req.master),
    .sec_viol(prog_sec),
    .rwx_viol(prog_rwx),
    .secure_fault(prog_sf),
    .bus_fault(prog_bf),
    .access_event(prog_ev)
  );

  rag_fault_route u_ram_route (
    .valid(ram_req.valid),
    .master(ram_req.master),
    .sec_viol(ram_sec),
    .rwx_viol(ram_rwx),
    .secure_fault(ram_sf),
    .bus_fault(ram_bf),
    .access_event(ram_ev)
  );

  // responses; grant low keeps the memory untouched
  wire logic prog_bad = prog_sec || prog_rwx;
  wire logic ram_bad = ram_sec || ram_rwx;
  rag_pkg::rag_resp_t next_prog_resp;
  rag_pkg::rag_resp_t next_ram_resp;
  assign next_prog_resp.grant = prog_req.valid && !prog_bad;
  assign next_prog_resp.bus_error = prog_bad && prog_req.err_capable;
  assign next_prog_resp.entry = prog_hit;
  assign next_prog_resp.rdata = (prog_req.valid && !prog_bad) ? prog_mem_rdata : 32'h0;
  assign next_ram_resp.grant = ram_req.valid && !ram_bad;
  assign next_ram_resp.bus_error = ram_bad && ram_req.err_capable;
  assign next_ram_resp.entry = ram_hit;
  assign next_ram_resp.rdata = (ram_req.valid && !ram_bad) ? ram_mem_rdata : 32'h0;

  // sticky flags: write 1 clears, a same-cycle event wins
  wire logic clr_ep = wr_en && sel_ep && pwdata[0];
  wire logic clr_er = wr_en && sel_er && pwdata[0];
  wire logic next_evt_prog = prog_ev || (evt_prog && !clr_ep);
  wire logic next_evt_ram = ram_ev || (evt_ram && !clr_er);
  wire logic [1:0] next_inten = (wr_en && sel_ie) ? pwdata[1:0] : inten;
  wire logic next_irq = |({next_evt_ram, next_evt_prog} & next_inten);

  // both spaces share one fault pair; either can raise it
  wire logic next_secure_fault = prog_sf || ram_sf;
  wire logic next_bus_fault = prog_bf || ram_bf;

  // one flop per output keeps every block short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_resp <= '0;
    end else begin
      prog_resp <= next_prog_resp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_resp <= '0;
    end else begin
      ram_resp <= next_ram_resp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_fault_a <= 1'b0;
    end else begin
      secure_fault_a <= next_secure_fault;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_fault_b <= 1'b0;
    end else begin
      bus_fault_b <= next_bus_fault;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_access_error_event <= 1'b0;
    end else begin
      prog_access_error_event <= prog_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_access_error_event <= 1'b0;
    end else begin
      ram_access_error_event <= ram_ev;
    end
  end

  // sticky flags and their enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_prog <= 1'b0;
    end else begin
      evt_prog <= next_evt_prog;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ram <= 1'b0;
    end else begin
      evt_ram <= next_evt_ram;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten <= 2'h0;
    end else begin
      inten <= next_inten;
    end
  end

  // built from next values so irq moves in step with the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// ===== verification/rag_bus_master.sv
`default_nettype none
module rag_bus_master (
  input wire logic pclk,
  output rag_pkg::rag_req_t prog_req,
  output rag_pkg::rag_req_t ram_req,
  output logic [31:0] prog_mem_rdata,
  output logic [31:0] ram_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    prog_req = '0;
    ram_req = '0;
  end
  // idle data is inverted so a stale word never passes as good data
  assign prog_mem_rdata = prog_req.valid ? {12'ha5a, prog_req.addr} : ~{12'ha5a, prog_req.addr};
  assign ram_mem_rdata = ram_req.valid ? {12'ha5a, ram_req.addr} : ~{12'ha5a, ram_req.addr};
  // one request cycle; err_capable comes from the caller
  task automatic issue(input logic sp, input rag_pkg::rag_req_t r);
    @(posedge pclk);
    if (sp) begin
      ram_req <= r;
    end else begin
      prog_req <= r;
    end
    @(posedge pclk);
    prog_req <= '0;
    ram_req <= '0;
  endtask
endmodule
`default_nettype wire

// ===== verification/rag_guard_properties.sv
`default_nettype none
module rag_guard_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire rag_pkg::rag_req_t prog_req,
  input wire logic [31:0] prog_mem_rdata,
  input wire rag_pkg::rag_resp_t prog_resp,
  input wire rag_pkg::rag_req_t ram_req,
  input wire rag_pkg::rag_resp_t ram_resp,
  input wire logic secure_fault_a,
  input wire logic bus_fault_b,
  input wire logic prog_access_error_event,
  input wire logic ram_access_error_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic core_p = prog_req.valid && prog_req.master == rag_pkg::rag_core;
  wire logic core_r = ram_req.valid && ram_req.master == rag_pkg::rag_core;
  wire logic cfg = prog_req.valid && prog_req.area != rag_pkg::rag_main;
  AST_BLOCK_ZERO: assert property (!prog_resp.grant |-> prog_resp.rdata == 32'h0)
    else $error("blocked program read leaked data");
  AST_RAM_ZERO: assert property (!ram_resp.grant |-> ram_resp.rdata == 32'h0)
    else $error("blocked ram read leaked data");
  AST_READ_PASS: assert property (prog_resp.grant && $past(prog_req.kind) == rag_pkg::rag_read
    |-> prog_resp.rdata == $past(prog_mem_rdata)) else $error("granted read lost its data");
  AST_NO_ERR_LINE: assert property (prog_req.valid && !prog_req.err_capable |=> !prog_resp.bus_error)
    else $error("bus error sent to master without error lines");
  AST_CFG_SEC: assert property (core_p && cfg && !prog_req.secure |=> secure_fault_a && !prog_resp.grant)
    else $error("non-secure config access not faulted");
  AST_CFG_FETCH: assert property (cfg && prog_req.kind == rag_pkg::rag_fetch && !prog_req.debug
    |=> !prog_resp.grant) else $error("config fetch granted");
  AST_FACTORY_RO: assert property (prog_req.valid && prog_req.area == rag_pkg::rag_factory_cfg
    && prog_req.kind inside {rag_pkg::rag_write, rag_pkg::rag_erase} |=> !prog_resp.grant)
    else $error("factory area write granted");
  AST_SF_SOURCE: assert property (secure_fault_a |-> $past(core_p || core_r))
    else $error("secure fault without core request");
  AST_BF_EVENT: assert property (bus_fault_b |-> prog_access_error_event || ram_access_error_event)
    else $error("bus fault without access event");
  AST_NONCORE: assert property (!core_p && !core_r |=> !secure_fault_a && !bus_fault_b)
    else $error("fault raised for non-core master");
  AST_GRANT_CLEAN: assert property (prog_resp.grant |-> !prog_resp.bus_error)
    else $error("granted transfer flagged as error");
  cover property (secure_fault_a);
  cover property (bus_fault_b && ram_access_error_event);
  cover property (prog_resp.entry);
  cover property (ram_resp.entry && !ram_resp.grant);
endmodule
bind rag_guard rag_guard_properties i_props (.pclk, .presetn, .prog_req, .prog_mem_rdata, .prog_resp,
  .ram_req, .ram_resp, .secure_fault_a, .bus_fault_b, .prog_access_error_event, .ram_access_error_event);
`default_nettype wire

// ===== verification/rag_guard_tb.sv
`default_nettype none
module rag_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam rag_pkg::rag_kind_t k_rd = rag_pkg::rag_read;
  localparam rag_pkg::rag_kind_t k_wr = rag_pkg::rag_write;
  localparam rag_pkg::rag_kind_t k_er = rag_pkg::rag_erase;
  localparam rag_pkg::rag_kind_t k_fe = rag_pkg::rag_fetch;
  localparam rag_pkg::rag_area_t a_mn = rag_pkg::rag_main;
  localparam rag_pkg::rag_area_t a_us = rag_pkg::rag_user_cfg;
  localparam rag_pkg::rag_area_t a_fc = rag_pkg::rag_factory_cfg;
  localparam rag_pkg::rag_master_t m_c = rag_pkg::rag_core;
  localparam rag_pkg::rag_master_t m_d = rag_pkg::rag_dma;
  localparam rag_pkg::rag_master_t m_o = rag_pkg::rag_other;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, prog_mem_rdata, ram_mem_rdata;
  logic pready, pslverr, secure_fault_a, bus_fault_b, prog_access_error_event, ram_access_error_event, irq;
  rag_pkg::rag_req_t prog_req, ram_req;
  rag_pkg::rag_resp_t prog_resp, ram_resp;
  int err_total = 0, checks_done = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  rag_bus_master i_mst (.pclk, .prog_req, .ram_req, .prog_mem_rdata, .ram_mem_rdata);
  rag_guard i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .prog_req, .prog_mem_rdata, .prog_resp, .ram_req, .ram_mem_rdata, .ram_resp, .secure_fault_a,
    .bus_fault_b, .prog_access_error_event, .ram_access_error_event, .irq);
  task automatic summarize();
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // held until pready is seen at a rising edge; only the hang guard ends a lost answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic s);
    logic [31:0] q;
    logic e;
    apb(0, a, 32'h0, q, e);
    chk_word("prdata", x, q);
    chk_bit("pslverr", s, e);
  endtask
  // sed: secure, err_capable, debug; ex: grant, sfault, bfault, prog evt, ram evt, entry
  task automatic acc(input logic sp, input logic [19:0] a, input rag_pkg::rag_kind_t k,
      input rag_pkg::rag_area_t ar, input logic [2:0] sed, input rag_pkg::rag_master_t m, input logic [5:0] ex);
    rag_pkg::rag_resp_t rp;
    i_mst.issue(sp, '{1'b1, a, k, ar, sed[2], m, sed[1], sed[0]});
    #1;
    rp = sp ? ram_resp : prog_resp;
    chk_bit("grant", ex[5], rp.grant);
    chk_bit("bus_error", ~ex[5] & sed[1], rp.bus_error);
    chk_bit("entry", ex[0], rp.entry);
    chk_bit("secure_fault", ex[4], secure_fault_a);
    chk_bit("bus_fault", ex[3], bus_fault_b);
    chk_bit("prog_event", ex[2], prog_access_error_event);
    chk_bit("ram_event", ex[1], ram_access_error_event);
    if (!ex[5] || k inside {k_rd, k_fe}) begin
      chk_word("rdata", ex[5] ? {12'ha5a, a} : 32'h0, rp.rdata);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h00c, 32'hf, 1'b0);
    rd(12'h114, 32'hf, 1'b0);
    rd(12'h400, 32'h0, 1'b1);
    rd(12'h00e, 32'h0, 1'b1);
    acc(1'b0, 20'h18000, k_rd, a_mn, 3'h2, m_c, 6'h10);
    wr(12'h00c, 32'h5);
    acc(1'b0, 20'h18000, k_wr, a_mn, 3'h6, m_c, 6'h0c);
    acc(1'b0, 20'h18000, k_er, a_mn, 3'h6, m_c, 6'h0c);
    acc(1'b0, 20'h1fffc, k_rd, a_mn, 3'h2, m_c, 6'h20);
    acc(1'b0, 20'h20000, k_rd, a_mn, 3'h2, m_c, 6'h10);
    wr(12'h00c, 32'h4);
    acc(1'b0, 20'h18000, k_rd, a_mn, 3'h6, m_c, 6'h0c);
    acc(1'b0, 20'h18000, k_fe, a_mn, 3'h2, m_c, 6'h20);
    acc(1'b0, 20'h18000, k_rd, a_mn, 3'h0, m_d, 6'h04);
    wr(12'h00c, 32'h0);
    acc(1'b0, 20'h18000, k_fe, a_mn, 3'h3, m_c, 6'h20);
    acc(1'b0, 20'h18000, k_fe, a_mn, 3'h2, m_c, 6'h0c);
    wr(12'h00c, 32'h101);
    wr(12'h00c, 32'hf);
    rd(12'h00c, 32'h101, 1'b0);
    wr(12'h108, 32'h0);
    acc(1'b1, 20'h04000, k_wr, a_mn, 3'h2, m_d, 6'h02);
    acc(1'b1, 20'h00000, k_rd, a_mn, 3'h2, m_c, 6'h10);
    wr(12'h104, 32'h8);
    acc(1'b1, 20'h02000, k_wr, a_mn, 3'h2, m_c, 6'h10);
    acc(1'b1, 20'h02000, k_wr, a_mn, 3'h6, m_c, 6'h0a);
    acc(1'b1, 20'h02000, k_rd, a_mn, 3'h2, m_o, 6'h02);
    wr(12'h208, 32'h201);
    rd(12'h208, 32'h201, 1'b0);
    acc(1'b1, 20'h03fc0, k_rd, a_mn, 3'h6, m_c, 6'h0b);
    acc(1'b1, 20'h03fbc, k_fe, a_mn, 3'h6, m_c, 6'h0a);
    wr(12'h200, 32'h105);
    wr(12'h204, 32'h305);
    acc(1'b0, 20'h2ffc0, k_rd, a_mn, 3'h6, m_c, 6'h21);
    acc(1'b0, 20'h2ff7c, k_rd, a_mn, 3'h6, m_c, 6'h20);
    wr(12'h200, 32'h005);
    wr(12'h204, 32'h703);
    rd(12'h204, 32'h703, 1'b0);
    acc(1'b0, 20'h2fffc, k_rd, a_mn, 3'h6, m_c, 6'h20);
    acc(1'b0, 20'h1fffc, k_rd, a_mn, 3'h2, m_c, 6'h20);
    acc(1'b0, 20'h00000, k_rd, a_us, 3'h2, m_c, 6'h10);
    acc(1'b0, 20'h00000, k_wr, a_us, 3'h6, m_c, 6'h20);
    acc(1'b0, 20'h00000, k_wr, a_fc, 3'h4, m_o, 6'h04);
    acc(1'b0, 20'h00000, k_rd, a_fc, 3'h6, m_c, 6'h20);
    acc(1'b0, 20'h00000, k_fe, a_us, 3'h4, m_o, 6'h04);
    acc(1'b0, 20'h00000, k_fe, a_us, 3'h7, m_c, 6'h20);
    rd(12'h300, 32'h1, 1'b0);
    rd(12'h304, 32'h1, 1'b0);
    chk_bit("irq", 1'b0, irq);
    wr(12'h308, 32'h1);
    rd(12'h308, 32'h1, 1'b0);
    chk_bit("irq", 1'b1, irq);
    wr(12'h300, 32'h1);
    rd(12'h300, 32'h0, 1'b0);
    chk_bit("irq", 1'b0, irq);
    wr(12'h308, 32'h2);
    rd(12'h308, 32'h2, 1'b0);
    chk_bit("irq", 1'b1, irq);
    wr(12'h304, 32'h1);
    rd(12'h304, 32'h0, 1'b0);
    chk_bit("irq", 1'b0, irq);
    summarize();
  end
  // hang guard well above the run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
endmodule
`default_nettype wire
